/* File: asf_consts.svh */
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define ASF_CLK_HZ        10000000
`define ASF_BAUD          1250000
`define ASF_GAP_MS        100
`define ASF_TLM_PERIOD_S  60

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define ASF_PREAMBLE      16'hA140
`define ASF_CRC_POLY      24'hFFF409
`define ASF_LONG_BITS     7'd112
`define ASF_SHORT_BITS    7'd56
`define ASF_LONG_CRC_AT   7'd88
`define ASF_SHORT_CRC_AT  7'd32
`define ASF_DF_ALLCALL    5'd11
`define ASF_DF_EXTSQ      5'd17
`define ASF_MODEL_ENG     8'h0E
`define ASF_MODEL_FLT     8'h0F
`define ASF_INIT_PATTERN  104'h00112233445566778899AABBCC

// ----------------------------------------------------------------
// Sentence characters and lengths
// ----------------------------------------------------------------
`define ASF_CH_STAR       8'h2A
`define ASF_CH_SEMI       8'h3B
`define ASF_CH_CR         8'h0D
`define ASF_CH_LF         8'h0A
`define ASF_CH_HASH       8'h23
`define ASF_CH_DOT        8'h2E
`define ASF_CH_COMMA      8'h2C
`define ASF_CH_V          8'h56
`define ASF_CH_M          8'h6D
`define ASF_CH_A          8'h41
`define ASF_CH_C          8'h43
`define ASF_CH_PLUS       8'h2B
`define ASF_CH_MINUS      8'h2D
`define ASF_TLM_LEN       6'd31
`define ASF_FRAME_EXTRA   6'd4

`endif

/* File: asf_pkg.sv */
package asf_pkg;

   typedef enum logic [1:0] {CAP_SEARCH, CAP_DATA, CAP_PUSH} asf_cap_t;
   typedef enum logic {SER_IDLE, SER_SEND} asf_ser_t;
   typedef enum logic [1:0] {KIND_INIT, KIND_TLM, KIND_FRAME} asf_kind_t;

   typedef struct packed {
      logic         longFrame;
      logic [111:0] data;
   } asf_frame_t;

   typedef struct packed {
      logic [11:0] voltBcd;
      logic [15:0] currBcd;
      logic        tempNeg;
      logic [7:0]  tempBcd;
   } asf_tlm_t;

endpackage : asf_pkg

/* File: asf_squitter_serializer.sv */
`timescale 1ns/1ns
`default_nettype none
`include "asf_consts.svh"
// Notes on behaviour
// [RQ1] UART output 1250000 baud, 8-N-1
// [RQ2] Bit rate fixed at build, 9600 to 1.25M
// [RQ3] Search header continuously, then capture datagram
// [RQ4] Recover 1 Mbps bits, 56 or 112 long
// [RQ5] Pass only formats 11 and 17
// [RQ6] Send only when check value matches
// [RQ7] ASCII build: two hex chars, high first
// [RQ8] ASCII sentences fixed 18 or 32 chars
// [RQ9] Binary build: raw bytes, 11 or 18 chars
// [RQ10] Star prefix; semicolon, CR, LF suffix
// [RQ11] Initial sentence first: model byte, pattern
// [RQ12] Telemetry every 60 s: V, I, T, count
// [RQ13] Telemetry: hash, fixed comma fields, semicolon
// [RQ14] Temperature always signed, two digits
// [RQ15] Eight-digit counter wraps 99999999 to zero
// [RQ16] Activity on while datagram is sent
// [RQ17] No receive input; format fixed at build
// [RQ18] Host reads address after first byte
// [RQ19] Engineering build spaces frames 100 ms
// [RQ20] Telemetry at least once per minute
// [RQ21] 24-bit Mode S parity over leading bits
// [RQ22] Idle high, start bit low, LSB first
// [RQ23] Counter counts passing frames, clears on reset

module asf_squitter_serializer
   import asf_pkg::*;
#(
   parameter int unsigned BAUD         = `ASF_BAUD,
   parameter bit          FLIGHT_BUILD = 1'b1,
   parameter bit          BINARY_OUT   = 1'b0,
   parameter int unsigned DEPTH        = 2,
   parameter int unsigned TLM_CYC      = `ASF_TLM_PERIOD_S * `ASF_CLK_HZ,
   parameter int unsigned GAP_CYC      = `ASF_GAP_MS * (`ASF_CLK_HZ / 1000)
)
(
   input  wire logic     clk,
   input  wire logic     rst_n,
   input  wire logic     clkEn,
   input  wire logic     chipIn,
   input  wire logic     chipValid,
   input  wire asf_tlm_t tlmIn,
   output logic          txd,
   output logic          activity
);

   localparam int unsigned DIV = `ASF_CLK_HZ / BAUD;   // [RQ1] [RQ2]
   localparam int unsigned AW  = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [23:0] crcStep(logic [23:0] c, logic b);
      return {c[22:0], 1'b0} ^ ((c[23] ^ b) ? `ASF_CRC_POLY : 24'h0);
   endfunction : crcStep

   function automatic logic [31:0] bcdInc(logic [31:0] v);
      logic [31:0] r;
      logic        cy;
      r  = v;
      cy = 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         if (cy)
         begin
            if (r[4*k +: 4] == 4'h9)
               r[4*k +: 4] = 4'h0;   // [RQ15]
            else
            begin
               r[4*k +: 4] = r[4*k +: 4] + 4'h1;
               cy          = 1'b0;
            end
         end
      end
      return r;
   endfunction : bcdInc

   function automatic logic [7:0] digAsc(logic [3:0] d);
      return {4'h3, d};
   endfunction : digAsc

   function automatic logic [7:0] hexAsc(logic [3:0] d);
      return (d < 4'hA) ? {4'h3, d} : 8'h37 + {4'h0, d};   // [RQ7]
   endfunction : hexAsc

   function automatic logic [5:0] payLen(logic lng);
      if (BINARY_OUT)
         return lng ? 6'd14 : 6'd7;   // [RQ9] [RQ17]
      return lng ? 6'd28 : 6'd14;     // [RQ8]
   endfunction : payLen

   function automatic logic [7:0] tlmChar(logic [5:0] i, asf_tlm_t t,
                                          logic [31:0] c);
      logic [7:0] ch;
      ch = `ASF_CH_LF;
      case (i)   // [RQ13] [RQ14]
         6'd0:  ch = `ASF_CH_HASH;
         6'd1:  ch = digAsc(t.voltBcd[11:8]);
         6'd2:  ch = `ASF_CH_DOT;
         6'd3:  ch = digAsc(t.voltBcd[7:4]);
         6'd4:  ch = digAsc(t.voltBcd[3:0]);
         6'd5:  ch = `ASF_CH_V;
         6'd6:  ch = `ASF_CH_COMMA;
         6'd7:  ch = digAsc(t.currBcd[15:12]);
         6'd8:  ch = digAsc(t.currBcd[11:8]);
         6'd9:  ch = digAsc(t.currBcd[7:4]);
         6'd10: ch = `ASF_CH_DOT;
         6'd11: ch = digAsc(t.currBcd[3:0]);
         6'd12: ch = `ASF_CH_M;
         6'd13: ch = `ASF_CH_A;
         6'd14: ch = `ASF_CH_COMMA;
         6'd15: ch = t.tempNeg ? `ASF_CH_MINUS : `ASF_CH_PLUS;
         6'd16: ch = digAsc(t.tempBcd[7:4]);
         6'd17: ch = digAsc(t.tempBcd[3:0]);
         6'd18: ch = `ASF_CH_C;
         6'd19: ch = `ASF_CH_COMMA;
         6'd28: ch = `ASF_CH_SEMI;
         6'd29: ch = `ASF_CH_CR;
         default:
         begin
            if (i >= 6'd20 && i <= 6'd27)
               ch = digAsc(c[31 - 4*int'(i - 6'd20) -: 4]);
         end
      endcase
      return ch;
   endfunction : tlmChar

   function automatic logic [7:0] charAt(asf_kind_t k, logic [5:0] i,
                                         asf_frame_t f, asf_tlm_t t,
                                         logic [31:0] c);
      logic [111:0] al;
      logic [5:0]   pl;
      logic [5:0]   j;
      logic [7:0]   ch;
      al = f.longFrame ? f.data : {f.data[55:0], 56'h0};
      pl = payLen(f.longFrame);
      j  = i - 6'd1;
      ch = `ASF_CH_LF;
      if (k == KIND_TLM)
         ch = tlmChar(i, t, c);
      else if (i == 6'd0)
         ch = `ASF_CH_STAR;   // [RQ10]
      else if (i <= pl)
      begin
         if (BINARY_OUT)
            ch = al[111 - 8*int'(j) -: 8];   // [RQ9]
         else
            ch = hexAsc(al[111 - 4*int'(j) -: 4]);   // [RQ7]
      end
      else if (i == pl + 6'd1)
         ch = `ASF_CH_SEMI;   // [RQ10]
      else if (i == pl + 6'd2)
         ch = `ASF_CH_CR;
      return ch;
   endfunction : charAt

   // ----------------------------------------------------------------
   // Capture: header search, bit recovery, filter and check
   // ----------------------------------------------------------------
   asf_cap_t     capSt_ff, nxt_capSt;
   logic [15:0]  chipSr_ff, nxt_chipSr;
   logic         phase_ff, nxt_phase;
   logic [6:0]   bitCnt_ff, nxt_bitCnt;
   logic [111:0] dat_ff, nxt_dat;
   logic [23:0]  crc_ff, nxt_crc;
   logic         longF_ff, nxt_longF;
   logic [31:0]  sqCnt_ff, nxt_sqCnt;
   logic         pushValid, pushReady;
   logic         lngNow;
   logic [4:0]   df;

   always_comb
   begin
      nxt_capSt  = capSt_ff;
      nxt_chipSr = chipSr_ff;
      nxt_phase  = phase_ff;
      nxt_bitCnt = bitCnt_ff;
      nxt_dat    = dat_ff;
      nxt_crc    = crc_ff;
      nxt_longF  = longF_ff;
      nxt_sqCnt  = sqCnt_ff;
      pushValid  = 1'b0;
      lngNow     = (bitCnt_ff == 7'd0) ? chipIn : longF_ff;
      df         = longF_ff ? dat_ff[111:107] : dat_ff[55:51];
      case (capSt_ff)
         CAP_SEARCH:
         begin
            if (chipValid)
            begin
               nxt_chipSr = {chipSr_ff[14:0], chipIn};   // [RQ3]
               if ({chipSr_ff[14:0], chipIn} == `ASF_PREAMBLE)
               begin
                  nxt_capSt  = CAP_DATA;
                  nxt_chipSr = 16'h0;
                  nxt_phase  = 1'b0;
                  nxt_bitCnt = 7'd0;
                  nxt_crc    = 24'h0;
                  nxt_dat    = 112'h0;
               end
            end
         end
         CAP_DATA:
         begin
            if (chipValid)
            begin
               nxt_phase = ~phase_ff;
               if (!phase_ff)
               begin
                  nxt_dat    = {dat_ff[110:0], chipIn};   // [RQ4]
                  nxt_longF  = lngNow;
                  nxt_bitCnt = bitCnt_ff + 7'd1;
                  if (bitCnt_ff < (lngNow ? `ASF_LONG_CRC_AT
                                          : `ASF_SHORT_CRC_AT))
                     nxt_crc = crcStep(crc_ff, chipIn);   // [RQ21]
                  if (bitCnt_ff + 7'd1 == (lngNow ? `ASF_LONG_BITS
                                                  : `ASF_SHORT_BITS))
                     nxt_capSt = CAP_PUSH;
               end
            end
         end
         CAP_PUSH:
         begin
            if (((df == `ASF_DF_ALLCALL) || (df == `ASF_DF_EXTSQ))   // [RQ5]
                && (dat_ff[23:0] == crc_ff))                         // [RQ6]
            begin
               pushValid = 1'b1;
               if (pushReady)
               begin
                  nxt_sqCnt = bcdInc(sqCnt_ff);   // [RQ23]
                  nxt_capSt = CAP_SEARCH;
               end
            end
            else
               nxt_capSt = CAP_SEARCH;
         end
         default: nxt_capSt = CAP_SEARCH;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         capSt_ff  <= CAP_SEARCH;
         chipSr_ff <= 16'h0;
         phase_ff  <= 1'b0;
         bitCnt_ff <= 7'd0;
         dat_ff    <= 112'h0;
         crc_ff    <= 24'h0;
         longF_ff  <= 1'b0;
         sqCnt_ff  <= 32'h0;   // [RQ23]
      end
      else if (clkEn)
      begin
         capSt_ff  <= nxt_capSt;
         chipSr_ff <= nxt_chipSr;
         phase_ff  <= nxt_phase;
         bitCnt_ff <= nxt_bitCnt;
         dat_ff    <= nxt_dat;
         crc_ff    <= nxt_crc;
         longF_ff  <= nxt_longF;
         sqCnt_ff  <= nxt_sqCnt;
      end
   end

   // ----------------------------------------------------------------
   // Frame buffer between capture and serializer
   // ----------------------------------------------------------------
   asf_frame_t        mem_ff [DEPTH];
   asf_frame_t        nxt_mem [DEPTH];
   logic [AW-1:0]     wrPtr_ff, nxt_wrPtr, rdPtr_ff, nxt_rdPtr;
   logic [AW:0]       fill_ff, nxt_fill;
   logic              popValid, popReady;
   asf_frame_t        popData;

   always_comb
   begin
      nxt_mem   = mem_ff;
      nxt_wrPtr = wrPtr_ff;
      nxt_rdPtr = rdPtr_ff;
      nxt_fill  = fill_ff;
      pushReady = (fill_ff != (AW+1)'(DEPTH));
      popValid  = (fill_ff != '0);
      popData   = mem_ff[rdPtr_ff];
      if (pushValid && pushReady)
      begin
         nxt_mem[wrPtr_ff] = '{longFrame: longF_ff, data: dat_ff};
         nxt_wrPtr = (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (popValid && popReady)
         nxt_rdPtr = (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
      if ((pushValid && pushReady) && !(popValid && popReady))
         nxt_fill = fill_ff + 1'b1;
      else if (!(pushValid && pushReady) && (popValid && popReady))
         nxt_fill = fill_ff - 1'b1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int k = 0; k < DEPTH; k++)
            mem_ff[k] <= '0;
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         fill_ff  <= '0;
      end
      else if (clkEn)
      begin
         mem_ff   <= nxt_mem;
         wrPtr_ff <= nxt_wrPtr;
         rdPtr_ff <= nxt_rdPtr;
         fill_ff  <= nxt_fill;
      end
   end

   // ----------------------------------------------------------------
   // Sentence sequencer and UART transmitter
   // ----------------------------------------------------------------
   asf_ser_t    serSt_ff, nxt_serSt;
   asf_kind_t   kind_ff, nxt_kind;
   logic [5:0]  idx_ff, nxt_idx;
   asf_frame_t  pay_ff, nxt_pay;
   asf_tlm_t    tSnap_ff, nxt_tSnap;
   logic [31:0] cSnap_ff, nxt_cSnap;
   logic        initDone_ff, nxt_initDone;
   logic        tlmDue_ff, nxt_tlmDue;
   logic [31:0] tlmCnt_ff, nxt_tlmCnt;
   logic [31:0] gapCnt_ff, nxt_gapCnt;
   logic [8:0]  txSr_ff, nxt_txSr;
   logic [3:0]  txBits_ff, nxt_txBits;
   logic [15:0] txDiv_ff, nxt_txDiv;
   logic        txd_ff, nxt_txd;
   logic        act_ff, nxt_act;
   logic [5:0]  sentLen;
   logic [7:0]  curChar;

   always_comb
   begin
      nxt_serSt    = serSt_ff;
      nxt_kind     = kind_ff;
      nxt_idx      = idx_ff;
      nxt_pay      = pay_ff;
      nxt_tSnap    = tSnap_ff;
      nxt_cSnap    = cSnap_ff;
      nxt_initDone = initDone_ff;
      nxt_tlmDue   = tlmDue_ff;
      nxt_tlmCnt   = tlmCnt_ff;
      nxt_gapCnt   = gapCnt_ff;
      nxt_txSr     = txSr_ff;
      nxt_txBits   = txBits_ff;
      nxt_txDiv    = txDiv_ff;
      nxt_txd      = txd_ff;
      nxt_act      = act_ff;
      popReady     = 1'b0;
      sentLen = (kind_ff == KIND_TLM) ? `ASF_TLM_LEN
              : payLen(pay_ff.longFrame) + `ASF_FRAME_EXTRA;
      curChar = charAt(kind_ff, idx_ff, pay_ff, tSnap_ff, cSnap_ff);
      if (gapCnt_ff != 32'h0)
         nxt_gapCnt = gapCnt_ff - 32'h1;
      // One bit period per DIV cycles, stop bit included
      if (txBits_ff != 4'h0)
      begin
         if (txDiv_ff == 16'h0)
         begin
            nxt_txDiv  = 16'(DIV - 1);
            nxt_txBits = txBits_ff - 4'h1;
            if (txBits_ff > 4'h1)
            begin
               nxt_txd  = txSr_ff[0];   // [RQ22]
               nxt_txSr = {1'b1, txSr_ff[8:1]};
            end
         end
         else
            nxt_txDiv = txDiv_ff - 16'h1;
      end
      case (serSt_ff)
         SER_IDLE:
         begin
            nxt_idx = 6'd0;
            if (!initDone_ff)
            begin
               nxt_initDone = 1'b1;   // [RQ11]
               nxt_kind     = KIND_INIT;
               nxt_pay      = '{longFrame: 1'b1,
                                data: {FLIGHT_BUILD ? `ASF_MODEL_FLT
                                                    : `ASF_MODEL_ENG,
                                       `ASF_INIT_PATTERN}};
               nxt_serSt    = SER_SEND;
            end
            else if (tlmDue_ff)
            begin
               nxt_tlmDue = 1'b0;   // [RQ12]
               nxt_kind   = KIND_TLM;
               nxt_tSnap  = tlmIn;
               nxt_cSnap  = sqCnt_ff;
               nxt_serSt  = SER_SEND;
            end
            else if (popValid && (gapCnt_ff == 32'h0))   // [RQ19]
            begin
               popReady  = 1'b1;
               nxt_kind  = KIND_FRAME;
               nxt_pay   = popData;
               nxt_act   = 1'b1;   // [RQ16]
               nxt_serSt = SER_SEND;
            end
         end
         SER_SEND:
         begin
            if (txBits_ff == 4'h0)
            begin
               if (idx_ff == sentLen)
               begin
                  nxt_serSt = SER_IDLE;
                  nxt_act   = 1'b0;   // [RQ16]
                  if (kind_ff == KIND_FRAME && !FLIGHT_BUILD)
                     nxt_gapCnt = GAP_CYC;   // [RQ19]
               end
               else
               begin
                  nxt_txd    = 1'b0;   // [RQ22]
                  nxt_txSr   = {1'b1, curChar};   // [RQ1]
                  nxt_txBits = 4'd10;
                  nxt_txDiv  = 16'(DIV - 1);
                  nxt_idx    = idx_ff + 6'd1;
               end
            end
         end
         default: nxt_serSt = SER_IDLE;
      endcase
      // Timer expiry after the clear so a coincident tick is kept
      if (tlmCnt_ff == TLM_CYC - 1)
      begin
         nxt_tlmCnt = 32'h0;
         nxt_tlmDue = 1'b1;   // [RQ20]
      end
      else
         nxt_tlmCnt = tlmCnt_ff + 32'h1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         serSt_ff    <= SER_IDLE;
         kind_ff     <= KIND_INIT;
         idx_ff      <= 6'd0;
         pay_ff      <= '0;
         tSnap_ff    <= '0;
         cSnap_ff    <= 32'h0;
         initDone_ff <= 1'b0;
         tlmDue_ff   <= 1'b0;
         tlmCnt_ff   <= 32'h0;
         gapCnt_ff   <= 32'h0;
         txSr_ff     <= 9'h1FF;
         txBits_ff   <= 4'h0;
         txDiv_ff    <= 16'h0;
         txd_ff      <= 1'b1;   // [RQ22]
         act_ff      <= 1'b0;
      end
      else if (clkEn)
      begin
         serSt_ff    <= nxt_serSt;
         kind_ff     <= nxt_kind;
         idx_ff      <= nxt_idx;
         pay_ff      <= nxt_pay;
         tSnap_ff    <= nxt_tSnap;
         cSnap_ff    <= nxt_cSnap;
         initDone_ff <= nxt_initDone;
         tlmDue_ff   <= nxt_tlmDue;
         tlmCnt_ff   <= nxt_tlmCnt;
         gapCnt_ff   <= nxt_gapCnt;
         txSr_ff     <= nxt_txSr;
         txBits_ff   <= nxt_txBits;
         txDiv_ff    <= nxt_txDiv;
         txd_ff      <= nxt_txd;
         act_ff      <= nxt_act;
      end
   end

   assign txd      = txd_ff;
   assign activity = act_ff;

endmodule : asf_squitter_serializer
`default_nettype wire

/* File: asf_squitter_serializer_sva.sv */
`timescale 1ns/1ns
`default_nettype none
`include "asf_consts.svh"
module asf_squitter_serializer_sva
   import asf_pkg::*;
#(
   parameter int unsigned BAUD = `ASF_BAUD
)
(
   input wire logic     clk,
   input wire logic     rst_n,
   input wire logic     clkEn,
   input wire logic     chipIn,
   input wire logic     chipValid,
   input wire asf_tlm_t tlmIn,
   input wire logic     txd,
   input wire logic     activity
);
   localparam int unsigned DIV = `ASF_CLK_HZ / BAUD;

   // --------------------------------
   // Character cell tracker
   // --------------------------------
   logic        busy_ff;
   int unsigned cell_ff;
   logic [7:0]  idle_ff;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         busy_ff <= 1'b0;
         cell_ff <= 0;
         idle_ff <= 8'h00;
      end
      else if (clkEn)
      begin
         idle_ff <= !txd ? 8'h00 : idle_ff + 8'(!idle_ff[7]);
         if (!busy_ff && !txd)
         begin
            busy_ff <= 1'b1;
            cell_ff <= 1;
         end
         else if (busy_ff)
         begin
            busy_ff <= cell_ff != 10 * DIV - 1;
            cell_ff <= cell_ff == 10 * DIV - 1 ? 0 : cell_ff + 1;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_release_idle: assert property ($rose(rst_n) |-> txd && !activity)
      else $error("line not idle after reset");
   a_start_bit: assert property (busy_ff && cell_ff < DIV |-> !txd)
      else $error("start bit not low");
   a_stop_bit: assert property (busy_ff && cell_ff >= 9 * DIV |-> txd)
      else $error("stop bit not high");
   a_bit_hold: assert property (busy_ff && cell_ff % DIV != 0 |-> $stable(txd))
      else $error("bit changed inside its cell");
   a_act_lead: assert property ($rose(activity) |-> ##[0:2] !txd)
      else $error("activity without a start bit");
   a_act_trail: assert property ($fell(activity) |-> txd)
      else $error("activity fell inside a character");
   a_act_idle: assert property (idle_ff > 8'h50 && activity
      |-> !$past(activity, 2))
      else $error("activity high on idle line");
   a_freeze_hold: assert property (!clkEn |=> $stable(txd) && $stable(activity))
      else $error("outputs moved with clock enable low");
endmodule : asf_squitter_serializer_sva
`default_nettype wire

/* File: asf_host_uart_model.sv */
`timescale 1ns/1ns
`default_nettype none
module asf_host_uart_model
#(
   parameter int unsigned DIV = 8
)
(
   input wire logic clk,
   input wire logic txd
);
   string      lineQ[$];
   string      tlmQ[$];
   string      cur;
   string      lastAddr;
   int         stopErrs;
   logic [7:0] rxByte;

   // --------------------------------
   // Receiver, sampling mid-bit
   // --------------------------------
   initial
   begin
      cur = "";
      stopErrs = 0;
      forever
      begin
         @(negedge txd);
         repeat (DIV / 2) @(posedge clk);
         if (txd !== 1'b0) stopErrs++;
         for (int i = 0; i < 8; i++)
         begin
            repeat (DIV) @(posedge clk);
            rxByte[i] = txd;
         end
         repeat (DIV) @(posedge clk);
         if (txd !== 1'b1) stopErrs++;
         if (rxByte == 8'h2A || rxByte == 8'h23) cur = "";
         if (rxByte == 8'h0A && cur.len() > 1 && cur[cur.len() - 1] == 8'h0D)
         begin
            cur = cur.substr(0, cur.len() - 2);
            if (cur[0] == 8'h23) tlmQ.push_back(cur);
            else
            begin
               lineQ.push_back(cur);
               lastAddr = cur.substr(3, 8);
            end
         end
         else
            cur = {cur, string'(rxByte)};
      end
   end
endmodule : asf_host_uart_model
`default_nettype wire

/* File: asf_squitter_serializer_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "asf_consts.svh"
module asf_squitter_serializer_tb_top
   import asf_pkg::*;
;
   localparam int unsigned TLM = 6000;
   typedef struct {
      logic [111:0] d;
      int           n;
      bit           bad;
      bit           pass;
   } asf_row_t;

   logic         clk;
   logic         rst_n;
   logic         clkEn;
   logic         chipIn;
   logic         chipValid;
   asf_tlm_t     tlmIn;
   logic         txd;
   logic         txdEng;
   logic         activity;
   int           failCount;
   int           nChecks;
   asf_row_t     rows [6];
   logic [111:0] f;
   logic [111:0] burst [3];
   string        s;

   asf_squitter_serializer #(.TLM_CYC(TLM)) u_dut (.clk(clk), .rst_n(rst_n),
      .clkEn(clkEn), .chipIn(chipIn), .chipValid(chipValid), .tlmIn(tlmIn),
      .txd(txd), .activity(activity));
   asf_squitter_serializer #(.FLIGHT_BUILD(1'b0), .TLM_CYC(TLM), .GAP_CYC(200))
      u_eng (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .chipIn(chipIn),
      .chipValid(chipValid), .tlmIn(tlmIn), .txd(txdEng), .activity());
   asf_host_uart_model u_host (.clk(clk), .txd(txd));
   asf_host_uart_model u_host_eng (.clk(clk), .txd(txdEng));

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // --------------------------------
   // Helpers
   // --------------------------------
   task automatic chkStr(string what, string exp, string got);
      nChecks++;
      if (got != exp)
      begin
         failCount++;
         $display("wrong value %s expected %s seen %s", what, exp, got);
      end
   endtask : chkStr

   task automatic chkBit(string what, logic exp, logic got);
      nChecks++;
      if (got !== exp)
      begin
         failCount++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask : chkBit

   function automatic string hexOf(logic [111:0] d, int n);
      string h;
      h = "";
      for (int i = 0; i < n / 4; i++)
         h = {h, $sformatf("%h", d[111 - 4 * i -: 4])};
      return h.toupper();
   endfunction : hexOf

   function automatic logic [111:0] withPar(logic [111:0] d, int n, bit bad);
      logic [23:0]  c;
      logic [111:0] r;
      c = 24'h000000;
      for (int i = 0; i < n - 24; i++)
         c = {c[22:0], 1'b0} ^ ((c[23] ^ d[111 - i]) ? 24'hFFF409 : 24'h000000);
      r = d;
      r[135 - n -: 24] = c ^ (bad ? 24'h000100 : 24'h000000);
      return r;
   endfunction : withPar

   task automatic sendChip(logic c);
      @(negedge clk);
      chipIn = c;
      chipValid = 1'b1;
      @(negedge clk);
      chipValid = 1'b0;
   endtask : sendChip

   task automatic sendFrame(logic [111:0] d, int n);
      for (int i = 15; i >= 0; i--)
         sendChip(`ASF_PREAMBLE >> i);
      for (int i = 0; i < n; i++)
      begin
         sendChip(d[111 - i]);
         sendChip(!d[111 - i]);
      end
   endtask : sendFrame

   task automatic waitLine(output string l, input bit tlm);
      int k;
      k = 0;
      while ((tlm ? u_host.tlmQ.size() : u_host.lineQ.size()) == 0 && k < 16000)
      begin
         @(posedge clk);
         k++;
      end
      l = "";
      if (tlm && u_host.tlmQ.size() > 0) l = u_host.tlmQ.pop_front();
      if (!tlm && u_host.lineQ.size() > 0) l = u_host.lineQ.pop_front();
   endtask : waitLine

   task automatic tlmStep(asf_tlm_t v, string exp);
      @(negedge clk);
      tlmIn = v;
      waitLine(s, 1'b1);
      chkStr("telemetry", exp, s);
   endtask : tlmStep

   task automatic endSim;
      $display("checks %0d mismatches %0d", nChecks, failCount);
      if (failCount == 0 && nChecks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : endSim

   initial
   begin
      repeat (99000) @(posedge clk);
      failCount++;
      endSim();
   end

   // --------------------------------
   // Main sequence
   // --------------------------------
   initial
   begin
      failCount = 0;
      nChecks = 0;
      rst_n = 1'b0;
      clkEn = 1'b1;
      chipIn = 1'b0;
      chipValid = 1'b0;
      tlmIn = '{12'h328, 16'h0756, 1'b0, 8'h22};
      rows = '{'{112'h8D4840D6202CC371C32CE0000000, 112, 0, 1},
               '{112'h5DA2A3D200000000000000000000, 56, 0, 1},
               '{112'h8D4840D6202CC371C32CE0000000, 112, 1, 0},
               '{112'h5DA2A3D200000000000000000000, 56, 1, 0},
               '{112'h2000183800000000000000000000, 56, 0, 0},
               '{112'hA0001838CA3E51F0A80000000000, 112, 0, 0}};
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      waitLine(s, 1'b0);
      chkStr("init", "*0F00112233445566778899AABBCC;", s);
      repeat (2) @(posedge clk);
      s = u_host_eng.lineQ.size() > 0 ? u_host_eng.lineQ.pop_front() : "";
      chkStr("init eng", "*0E00112233445566778899AABBCC;", s);
      foreach (rows[r])
      begin
         f = withPar(rows[r].d, rows[r].n, rows[r].bad);
         sendFrame(f, rows[r].n);
         if (rows[r].pass)
         begin
            waitLine(s, 1'b0);
            chkStr("squitter", {"*", hexOf(f, rows[r].n), ";"}, s);
            if (r == 0) chkStr("address", hexOf(f << 8, 24), u_host.lastAddr);
         end
         else
         begin
            repeat (5200) @(posedge clk);
            chkBit("dropped", 1'b1, u_host.lineQ.size() == 0);
         end
      end
      for (int i = 0; i < 3; i++)
      begin
         burst[i] = withPar(rows[0].d ^ (112'(i + 1) << 80), 112, 1'b0);
         sendFrame(burst[i], 112);
      end
      for (int i = 0; i < 3; i++)
      begin
         waitLine(s, 1'b0);
         chkStr("burst", {"*", hexOf(burst[i], 112), ";"}, s);
      end
      u_host.tlmQ.delete();
      waitLine(s, 1'b1);
      tlmStep('{12'h328, 16'h0756, 1'b0, 8'h22}, "#3.28V,075.6mA,+22C,00000005;");
      tlmStep('{12'h500, 16'h1234, 1'b0, 8'h00}, "#5.00V,123.4mA,+00C,00000005;");
      tlmStep('{12'h109, 16'h0000, 1'b1, 8'h05}, "#1.09V,000.0mA,-05C,00000005;");
      @(negedge clk);
      rst_n = 1'b0;
      clkEn = 1'b0;
      repeat (100) @(negedge clk);
      rst_n = 1'b1;
      repeat (30) @(negedge clk);
      chkBit("frozen line", 1'b1, txd);
      u_host.lineQ.delete();
      u_host.tlmQ.delete();
      clkEn = 1'b1;
      waitLine(s, 1'b0);
      chkStr("init again", "*0F00112233445566778899AABBCC;", s);
      waitLine(s, 1'b1);
      chkStr("count cleared", "#1.09V,000.0mA,-05C,00000000;", s);
      chkBit("framing", 1'b1, u_host.stopErrs == 0);
      endSim();
   end
endmodule : asf_squitter_serializer_tb_top

bind asf_squitter_serializer asf_squitter_serializer_sva #(.BAUD(BAUD)) u_sva (
   .clk(clk), .rst_n(rst_n), .clkEn(clkEn), .chipIn(chipIn),
   .chipValid(chipValid), .tlmIn(tlmIn), .txd(txd), .activity(activity));
`default_nettype wire
